// ### inc/smf_pkg.sv
package smf_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SUPPLY_FLT_NS = 10000;
  localparam int CORE_FLT_NS = 11000;
  localparam int THERM_FLT_NS = 3000;
  localparam int SUPPLY_FLT_CYC = (SUPPLY_FLT_NS * CLK_MHZ + 999) / 1000;
  localparam int CORE_FLT_CYC = (CORE_FLT_NS * CLK_MHZ + 999) / 1000;
  localparam int THERM_FLT_CYC = (THERM_FLT_NS * CLK_MHZ + 999) / 1000;
  localparam int CHECK_CYC = 16;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_MASK = 32'h0000_0004;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0008;
  localparam logic [31:0] ADDR_FLAGS = 32'h0000_000C;
  localparam int BIT_LOW = 0;
  localparam int BIT_HIGH = 1;
  localparam int BIT_CORE = 2;
  localparam int BIT_THERM = 3;
  localparam int BIT_CHKFAIL = 4;
  localparam int BIT_CLEAR = 0;
  localparam int BIT_CLR_EN = 1;
  localparam int BIT_CHK_START = 2;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  typedef enum logic [1:0] {SMF_SAFE, SMF_LOOP} smf_state_t;
endpackage

// ### inc/smf_flt_if.sv
`timescale 1ns/100ps
interface smf_flt_if;
  logic cond;
  logic hit;
  modport src (output cond, input hit);
  modport flt (input cond, output hit);
endinterface

// ### rtl/smf_filter.sv
`timescale 1ns/100ps
module smf_filter
  import smf_pkg::*;
#(
  parameter int COUNT = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  smf_flt_if.flt f
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic hit;
  logic next_hit;
  always_comb begin
    next_cnt = 16'h0000;
    next_hit = 1'b0;
    if (f.cond) begin
      next_cnt = (cnt == COUNT[15:0]) ? cnt : cnt + 16'h0001;
      next_hit = (cnt == COUNT[15:0]);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 16'h0000;
      hit <= 1'b0;
    end else begin
      cnt <= next_cnt;
      hit <= next_hit;
    end
  end
  assign f.hit = hit;
endmodule

// ### rtl/smf_selfcheck.sv
`timescale 1ns/100ps
module smf_selfcheck
  import smf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic hit,
  output logic inject,
  output logic fail
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic seen;
  logic next_seen;
  logic next_fail;
  // Window must outlast the slower filter, so the counter is wide
  always_comb begin
    next_cnt = cnt;
    next_seen = seen;
    next_fail = 1'b0;
    if (start && cnt == 16'h0000) begin
      next_cnt = 16'h0001;
      next_seen = 1'b0;
    end else if (cnt != 16'h0000) begin
      next_seen = seen | hit;
      if (cnt == 16'(CORE_FLT_CYC + CHECK_CYC)) begin
        next_cnt = 16'h0000;
        next_fail = ~(seen | hit);
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 16'h0000;
      seen <= 1'b0;
      fail <= 1'b0;
    end else begin
      cnt <= next_cnt;
      seen <= next_seen;
      fail <= next_fail;
    end
  end
  assign inject = (cnt != 16'h0000);
endmodule

// ### rtl/smf_supervisor.sv
`timescale 1ns/100ps
module smf_supervisor
  import smf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic supply_under,
  input wire logic supply_over,
  input wire logic core_rail_under,
  input wire logic core_rail_over,
  input wire logic core_overtemp,
  input wire logic loop1_enable,
  input wire logic loop2_enable,
  output logic supply_low_flag,
  output logic supply_high_flag,
  output logic internal_reset_flag,
  output logic analog_power_on_reset,
  output logic core_power_on_reset,
  output logic core_regulator_enable,
  output logic safe_tristate_state,
  output logic loop_on,
  output logic phase_outputs_oe_n,
  output logic irq
);
  smf_flt_if f_low();
  smf_flt_if f_high();
  smf_flt_if f_core();
  smf_flt_if f_therm();
  logic chk_start;
  logic chk_inject;
  logic chk_fail;
  logic chk_inject_q;
  logic chk_block;
  logic [1:0] en_q;
  logic en_rise;
  logic low_f, high_f, intr_f, therm_f;
  logic next_low_f, next_high_f, next_intr_f, next_therm_f;
  logic core_por;
  logic next_core_por;
  logic [4:0] status, next_status;
  logic [4:0] mask, next_mask;
  logic [1:0] ctrl, next_ctrl;
  logic clear_cmd;
  logic dp_act, dp_write, next_dp_act, next_dp_write;
  logic [3:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  smf_state_t state, next_state;
  logic next_anapor, next_safe, next_loop_on, next_oe_n, next_irq;

  // Self-check injects a fault into the supply-under and core rail monitors
  assign f_low.cond = supply_under | chk_inject;
  assign f_high.cond = supply_over;
  assign f_core.cond = core_rail_under | core_rail_over | chk_inject;
  assign f_therm.cond = core_overtemp;
  // Filter hits linger one cycle after injection ends
  assign chk_block = chk_inject | chk_inject_q;
  assign en_rise = (loop1_enable & ~en_q[0]) | (loop2_enable & ~en_q[1]);

  smf_filter #(.COUNT(SUPPLY_FLT_CYC)) u_flt_low (.hclk(hclk), .hresetn(hresetn), .f(f_low));
  smf_filter #(.COUNT(SUPPLY_FLT_CYC)) u_flt_high (.hclk(hclk), .hresetn(hresetn), .f(f_high));
  smf_filter #(.COUNT(CORE_FLT_CYC)) u_flt_core (.hclk(hclk), .hresetn(hresetn), .f(f_core));
  smf_filter #(.COUNT(THERM_FLT_CYC)) u_flt_therm (.hclk(hclk), .hresetn(hresetn), .f(f_therm));

  smf_selfcheck u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(chk_start),
    .hit(f_core.hit & f_low.hit),
    .inject(chk_inject),
    .fail(chk_fail)
  );

  function automatic logic [3:0] reg_index(input logic [31:0] a);
    reg_index = {a[31:4] == 28'h0000000 ? 1'b1 : 1'b0, 1'b0, a[3:2]};
  endfunction

  // Bus clear honoured only when enabled
  assign clear_cmd = dp_act && dp_write && dp_addr == {1'b1, 1'b0, ADDR_CTRL[3:2]}
                     && hwdata[BIT_CLEAR] && ctrl[BIT_CLR_EN];
  assign chk_start = dp_act && dp_write && dp_addr == {1'b1, 1'b0, ADDR_CTRL[3:2]}
                     && hwdata[BIT_CHK_START];

  always_comb begin
    next_low_f = low_f;
    next_high_f = high_f;
    next_intr_f = intr_f;
    next_therm_f = therm_f;
    next_core_por = 1'b1;
    if ((en_rise || clear_cmd) && !f_low.cond && !chk_inject) next_low_f = 1'b0;
    if ((en_rise || clear_cmd) && !f_high.cond) next_high_f = 1'b0;
    if ((en_rise || clear_cmd) && !f_core.cond) next_intr_f = 1'b0;
    if (f_low.hit && !chk_block) next_low_f = 1'b1;
    if (f_high.hit) next_high_f = 1'b1;
    if (f_core.hit && !chk_block) next_core_por = 1'b0;
    if (f_therm.hit) next_therm_f = 1'b1;
    else if (!f_therm.cond) next_therm_f = 1'b0;
  end

  always_comb begin
    next_anapor = ~(low_f | high_f);
    next_safe = 1'b1;
    next_state = state;
    case (state)
      SMF_SAFE: begin
        if (!low_f && !high_f && !intr_f && !f_low.cond && !f_high.cond
            && (loop1_enable || loop2_enable)) next_state = SMF_LOOP;
      end
      SMF_LOOP: begin
        if (low_f || high_f || (!loop1_enable && !loop2_enable)) next_state = SMF_SAFE;
      end
      default: next_state = SMF_SAFE;
    endcase
    if (!core_por) next_state = SMF_SAFE;
    next_safe = (next_state == SMF_SAFE);
    next_loop_on = (next_state == SMF_LOOP);
    next_oe_n = next_safe;
  end

  always_comb begin
    next_status = status;
    next_mask = mask;
    next_ctrl = ctrl;
    next_hrdata = 32'h0000_0000;
    next_dp_act = hsel && hready && htrans[1] && core_por;
    next_dp_write = hwrite;
    next_dp_addr = reg_index(haddr);
    if (next_dp_act && !hwrite) begin
      case (reg_index(haddr))
        {1'b1, 1'b0, ADDR_STATUS[3:2]}: next_hrdata = {27'h0, status};
        {1'b1, 1'b0, ADDR_MASK[3:2]}: next_hrdata = {27'h0, mask};
        {1'b1, 1'b0, ADDR_CTRL[3:2]}: next_hrdata = {30'h0, ctrl};
        {1'b1, 1'b0, ADDR_FLAGS[3:2]}:
          next_hrdata = {27'h0, chk_fail, therm_f, intr_f, high_f, low_f};
        default: next_hrdata = 32'h0000_0000;
      endcase
      if (reg_index(haddr) == {1'b1, 1'b0, ADDR_STATUS[3:2]}) next_status = 5'h00;
    end
    if (dp_act && dp_write) begin
      if (dp_addr == {1'b1, 1'b0, ADDR_MASK[3:2]}) next_mask = hwdata[4:0];
      if (dp_addr == {1'b1, 1'b0, ADDR_CTRL[3:2]}) next_ctrl = {hwdata[BIT_CLR_EN], 1'b0};
    end
    next_status = next_status | {chk_fail, next_therm_f & ~therm_f,
                                 next_intr_f & ~intr_f, next_high_f & ~high_f,
                                 next_low_f & ~low_f};
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 2'b11;
      chk_inject_q <= 1'b0;
      low_f <= 1'b0;
      high_f <= 1'b0;
      intr_f <= 1'b1;
      therm_f <= 1'b0;
      core_por <= 1'b1;
      status <= 5'h00;
      mask <= MASK_RESET;
      ctrl <= CTRL_RESET;
      dp_act <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 4'h0;
      hrdata <= 32'h0000_0000;
      state <= SMF_SAFE;
      analog_power_on_reset <= 1'b1;
      safe_tristate_state <= 1'b1;
      loop_on <= 1'b0;
      phase_outputs_oe_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      en_q <= {loop2_enable, loop1_enable};
      chk_inject_q <= chk_inject;
      low_f <= next_low_f;
      high_f <= next_high_f;
      intr_f <= core_por ? next_intr_f : 1'b1;
      therm_f <= next_therm_f;
      core_por <= next_core_por;
      status <= next_status;
      mask <= next_mask;
      ctrl <= next_ctrl;
      dp_act <= next_dp_act;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      state <= next_state;
      analog_power_on_reset <= next_anapor;
      safe_tristate_state <= next_safe;
      loop_on <= next_loop_on;
      phase_outputs_oe_n <= next_oe_n;
      irq <= next_irq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_low_flag <= 1'b0;
      supply_high_flag <= 1'b0;
      internal_reset_flag <= 1'b1;
      core_power_on_reset <= 1'b1;
      core_regulator_enable <= 1'b1;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      supply_low_flag <= next_low_f;
      supply_high_flag <= next_high_f;
      internal_reset_flag <= core_por ? next_intr_f : 1'b1;
      core_power_on_reset <= next_core_por;
      core_regulator_enable <= ~next_therm_f;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// ### testbench/smf_checker.sv
`timescale 1ns/100ps
module smf_checker
  import smf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic supply_under,
  input wire logic core_rail_under,
  input wire logic core_rail_over,
  input wire logic core_overtemp,
  input wire logic supply_low_flag,
  input wire logic supply_high_flag,
  input wire logic internal_reset_flag,
  input wire logic analog_power_on_reset,
  input wire logic core_power_on_reset,
  input wire logic core_regulator_enable,
  input wire logic safe_tristate_state,
  input wire logic loop_on
);
  logic [15:0] low_cnt, core_cnt, hot_cnt;
  logic [15:0] next_low_cnt, next_core_cnt, next_hot_cnt;
  // Wrapping run counts of the supply_under, core rail and core_overtemp fault levels
  always_comb begin
    next_low_cnt = supply_under ? low_cnt + 16'h0001 : 16'h0000;
    next_core_cnt = (core_rail_under || core_rail_over) ? core_cnt + 16'h0001 : 16'h0000;
    next_hot_cnt = core_overtemp ? hot_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 16'h0000;
      core_cnt <= 16'h0000;
      hot_cnt <= 16'h0000;
    end else begin
      low_cnt <= next_low_cnt;
      core_cnt <= next_core_cnt;
      hot_cnt <= next_hot_cnt;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  low_cnt_a: assert property ($rose(supply_low_flag) |-> low_cnt >= SUPPLY_FLT_CYC)
    else $error("low flag before filter time");
  por_drop_a: assert property ($rose(supply_high_flag) |-> ##[0:1] !analog_power_on_reset)
    else $error("analog reset not driven low");
  safe_enter_a: assert property (supply_low_flag || supply_high_flag |-> ##[0:2] safe_tristate_state)
    else $error("safe state missing");
  flag_hold_a: assert property (supply_under && supply_low_flag |=> supply_low_flag)
    else $error("low flag cleared during fault");
  core_cnt_a: assert property ($fell(core_power_on_reset) |-> core_cnt >= CORE_FLT_CYC)
    else $error("core reset before filter time");
  hot_cnt_a: assert property ($fell(core_regulator_enable) |-> hot_cnt >= THERM_FLT_CYC)
    else $error("regulator off before filter time");
  reg_back_a: assert property ($fell(core_overtemp) |-> ##[1:3] core_regulator_enable)
    else $error("regulator not restored");
  loop_gate_a: assert property ($rose(loop_on) |->
    !supply_low_flag && !supply_high_flag && !internal_reset_flag)
    else $error("loop on with a flag set");
  int_flag_a: assert property ($rose(hresetn) |-> internal_reset_flag)
    else $error("internal reset flag clear after reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule
bind smf_supervisor smf_checker smf_checker_i (.hclk, .hresetn, .hreadyout, .hresp,
  .supply_under, .core_rail_under, .core_rail_over, .core_overtemp, .supply_low_flag,
  .supply_high_flag, .internal_reset_flag, .analog_power_on_reset, .core_power_on_reset,
  .core_regulator_enable, .safe_tristate_state, .loop_on);

// ### testbench/smf_host.sv
`timescale 1ns/100ps
module smf_host
  import smf_pkg::*;
(
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic loop1_enable,
  output logic loop2_enable,
  output logic stuck
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, loop1_enable, loop2_enable, stuck} = '0;
    hsize = 3'h2;
  end
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (!hreadyout && n < 64);
    if (!hreadyout) stuck = 1'b1;
  endtask
  // Single word transfer; clear command is a CTRL write
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import smf_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, stuck;
  logic [31:0] haddr, hwdata, hrdata, seen, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic supply_under, supply_over, core_rail_under, core_rail_over, core_overtemp;
  logic loop1_enable, loop2_enable, supply_low_flag, supply_high_flag, internal_reset_flag;
  logic analog_power_on_reset, core_power_on_reset, core_regulator_enable;
  logic safe_tristate_state, loop_on, phase_outputs_oe_n;
  logic [31:0] exp_q[$];
  int failures = 0;
  int check_count = 0;
  event got;
  smf_supervisor smf_supervisor_i (.*, .hready(hreadyout));
  smf_host smf_host_i (.*);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic compare(input logic [31:0] v, input logic [31:0] e);
    check_count++;
    if (v !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  initial begin
    forever begin
      @(got);
      compare(seen, exp_q.pop_front());
    end
  end
  task automatic pin(input logic v, input logic e);
    exp_q.push_back({31'h0, e});
    seen = {31'h0, v};
    ->got;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    smf_host_i.xfer(1'b0, a, 32'h0, seen);
    ->got;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    smf_host_i.xfer(1'b1, a, d, r);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    complete_run();
  end
  initial begin
    int n;
    r = $urandom(19093);
    {supply_under, supply_over, core_rail_under, core_rail_over, core_overtemp} = 5'h00;
    hresetn = 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(2);
    pin(internal_reset_flag, 1'b1);
    rd(ADDR_FLAGS, 32'h0000_0004);
    smf_host_i.xfer(1'b0, ADDR_STATUS, 32'h0, r);
    wr(ADDR_MASK, 32'h0000_0001);
    smf_host_i.loop1_enable <= 1'b1;
    cyc(4);
    pin(internal_reset_flag, 1'b0);
    pin(loop_on, 1'b1);
    pin(phase_outputs_oe_n, 1'b0);
    repeat (2) begin
      supply_under <= 1'b1;
      cyc(100 + $urandom_range(1100));
      supply_under <= 1'b0;
      cyc(1);
    end
    pin(supply_low_flag, 1'b0);
    supply_under <= 1'b1;
    cyc(SUPPLY_FLT_CYC + 4);
    pin(supply_low_flag, 1'b1);
    pin(analog_power_on_reset, 1'b0);
    pin(safe_tristate_state, 1'b1);
    pin(irq, 1'b1);
    pin(loop_on, 1'b0);
    smf_host_i.loop2_enable <= 1'b1;
    cyc(3);
    pin(supply_low_flag, 1'b1);
    supply_under <= 1'b0;
    smf_host_i.loop2_enable <= 1'b0;
    rd(ADDR_STATUS, 32'h0000_0001);
    cyc(2);
    pin(irq, 1'b0);
    smf_host_i.loop2_enable <= 1'b1;
    cyc(3);
    pin(supply_low_flag, 1'b0);
    pin(analog_power_on_reset, 1'b1);
    supply_over <= 1'b1;
    cyc(SUPPLY_FLT_CYC + 4);
    pin(supply_high_flag, 1'b1);
    supply_over <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    pin(supply_high_flag, 1'b1);
    rd(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0003);
    cyc(2);
    pin(supply_high_flag, 1'b0);
    for (int i = 0; i < 2; i++) begin
      {core_rail_under, core_rail_over} <= (i == 0) ? 2'h2 : 2'h1;
      n = 0;
      while (core_power_on_reset && n < CORE_FLT_CYC + 20) begin
        cyc(1);
        n++;
      end
      pin(n >= CORE_FLT_CYC, 1'b1);
      {core_rail_under, core_rail_over} <= 2'h0;
      cyc(4);
      pin(internal_reset_flag, 1'b1);
      wr(ADDR_CTRL, 32'h0000_0003);
      cyc(2);
      pin(internal_reset_flag, 1'b0);
    end
    core_overtemp <= 1'b1;
    cyc(THERM_FLT_CYC - 2);
    pin(core_regulator_enable, 1'b1);
    cyc(6);
    pin(core_regulator_enable, 1'b0);
    core_overtemp <= 1'b0;
    cyc(4);
    pin(core_regulator_enable, 1'b1);
    wr(ADDR_CTRL, 32'h0000_0006);
    cyc(CORE_FLT_CYC + CHECK_CYC + 8);
    rd(ADDR_FLAGS, 32'h0000_0000);
    pin(core_power_on_reset, 1'b1);
    rd(32'h0000_0010, 32'h0000_0000);
    pin(stuck, 1'b0);
    complete_run();
  end
endmodule
